//--- two_wire_defines.svh
// constants for the two-wire slave receiver and its bus master
`ifndef TWO_WIRE_DEFINES_SVH
`define TWO_WIRE_DEFINES_SVH
// Notes on behaviour
// - upper seven own-address bits are slave address
// - address lsb enables general call response
// - software enables interface, start/stop requests zero
// - software sets ack_enable to answer addresses
// - addressed with write bit enters slave receive
// - own address plus write sets flag, status
// - lost arbitration then addressed enters slave receive
// - ack_enable cleared: next data byte gets NACK
// - ack_enable zero ignores address, bus still watched
// - deep sleep: address acknowledged on bus clock
// - sleep match wakes part, holds bus clock
// - data register not trusted after wake
// - status 0x60: next byte acked per ack_enable
// - status 0x68: next byte acked per ack_enable
// - status 0x70/0x78: next byte per ack_enable
// - status 0x80: read byte, continue per ack_enable
// - status 0x88: fall back to not addressed
// - status codes read with prescaler bits masked
// - general call data gives 0x90 or 0x98
// - stop or restart while addressed gives 0xA0

`define REG_OWN_ADDR    2'h0
`define REG_CONTROL     2'h1
`define REG_STATUS      2'h2
`define REG_DATA        2'h3

`define CTL_FLAG        7
`define CTL_ACK         6
`define CTL_START       5
`define CTL_STOP        4
`define CTL_WCOL        3
`define CTL_EN          2
`define CTL_IE          0
`define OWN_GCE         0

`define RST_OWN_ADDR    8'h00
`define RST_STATUS      8'hF8
`define GC_ADDR         8'h00

`define ST_OWN_W        8'h60
`define ST_ARB_OWN_W    8'h68
`define ST_GC           8'h70
`define ST_ARB_GC       8'h78
`define ST_DATA_ACK     8'h80
`define ST_DATA_NACK    8'h88
`define ST_GC_DATA_ACK  8'h90
`define ST_GC_DATA_NACK 8'h98
`define ST_STOP_RS      8'hA0

`define BIT_LAST        4'h7
`define BIT_ACK         4'h8

`define SYS_CLK_NS      10
`define SCL_HALF_NS     80
`define SCL_HALF_CYCLES ((`SCL_HALF_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`endif

//--- two_wire_pkg.sv
// types shared by both ends of the two-wire link
package two_wire_pkg;
   typedef enum logic [1:0] {
      EV_ADDR      = 2'h0,
      EV_DATA_ACK  = 2'h1,
      EV_DATA_NACK = 2'h2
   } ev_kind_type;

   typedef enum logic [1:0] {
      CMD_START = 2'h0,
      CMD_WRITE = 2'h1,
      CMD_STOP  = 2'h2
   } cmd_kind_type;

   typedef enum logic [7:0] {
      H_IDLE  = 8'h01,
      H_RS_LO = 8'h02,
      H_RS_HI = 8'h04,
      H_ST    = 8'h08,
      H_LO    = 8'h10,
      H_HI    = 8'h20,
      H_SP_LO = 8'h40,
      H_SP_HI = 8'h80
   } host_fsm_type;

   typedef struct packed {
      logic        start_s1;
      logic        frame_seen;
      logic [7:0]  addr_s1;
      logic [7:0]  addr_s2;
      logic [1:0]  ctl_s1;
      logic [1:0]  ctl_s2;
      logic [7:0]  shift;
      logic [3:0]  cnt;
      logic        first;
      logic        addressed;
      logic        gc;
      logic        sda_oe;
      logic        ev_tgl;
      logic        ev_gc;
      ev_kind_type ev_kind;
      logic [7:0]  ev_data;
   } link_state_type;

   typedef struct packed {
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      logic       ev_s1;
      logic       ev_s2;
      logic       ev_seen;
      logic       start_tgl;
      logic [7:0] own_addr;
      logic       flag;
      logic       ack_en;
      logic       start_req;
      logic       stop_req;
      logic       wcol;
      logic       en;
      logic       ie;
      logic [1:0] presc;
      logic [7:0] status;
      logic [7:0] data;
      logic       stretch;
      logic       active;
      logic       wake;
      logic [7:0] rdata;
   } sys_state_type;

   typedef struct packed {
      host_fsm_type fsm;
      logic [1:0]   scl_sync;
      logic [1:0]   sda_sync;
      logic [7:0]   cnt;
      logic [3:0]   idx;
      logic [7:0]   data;
      logic         scl_oe;
      logic         sda_oe;
      logic         owned;
      logic         done;
      logic         ack;
   } host_state_type;
endpackage

//--- two_wire_if.sv
// open-drain two-wire bus joining the bus master and the slave receiver
`timescale 1ns/100ps
interface two_wire_if;
   logic scl_host_out;
   logic scl_host_oe;
   logic sda_host_out;
   logic sda_host_oe;
   logic scl_dev_out;
   logic scl_dev_oe;
   logic sda_dev_out;
   logic sda_dev_oe;
   logic scl;
   logic sda;

   // wired-and with pull-up: any enabled driver pulls the line to its (low) level
   assign scl = !((scl_host_oe && !scl_host_out) || (scl_dev_oe && !scl_dev_out));
   assign sda = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));

   modport host (
      output scl_host_out,
      output scl_host_oe,
      output sda_host_out,
      output sda_host_oe,
      input  scl,
      input  sda
   );
   modport device (
      output scl_dev_out,
      output scl_dev_oe,
      output sda_dev_out,
      output sda_dev_oe,
      input  scl,
      input  sda
   );
endinterface

//--- two_wire_slave_receiver.sv
// slave receiver end: register file on the system clock, bit engine on the bus clock
`timescale 1ns/100ps
`include "two_wire_defines.svh"
module two_wire_slave_receiver (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [1:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       arb_lost,
   input  wire logic       sleep_deep,
   output logic            wake_request,
   output logic            start_request,
   output logic            stop_request,
   output logic      [1:0] bit_rate_prescale,
   two_wire_if.device      bus
);
   two_wire_pkg::link_state_type l_ff;
   two_wire_pkg::link_state_type nxt_l;
   two_wire_pkg::sys_state_type  s_ff;
   two_wire_pkg::sys_state_type  nxt_s;
   logic [7:0] byte_in;
   logic       own_hit;
   logic       gc_hit;
   logic       start_det;
   logic       stop_det;
   logic       byte_event;

   function automatic logic [7:0] status_of(input two_wire_pkg::ev_kind_type kind,
                                            input logic gc, input logic arb);
      logic [7:0] code;
      code = `ST_OWN_W;
      unique case (kind)
         two_wire_pkg::EV_ADDR:      code = gc ? (arb ? `ST_ARB_GC : `ST_GC)
                                               : (arb ? `ST_ARB_OWN_W : `ST_OWN_W);
         two_wire_pkg::EV_DATA_ACK:  code = gc ? `ST_GC_DATA_ACK : `ST_DATA_ACK;
         two_wire_pkg::EV_DATA_NACK: code = gc ? `ST_GC_DATA_NACK : `ST_DATA_NACK;
         default:                    code = `RST_STATUS;
      endcase
      return code;
   endfunction

   // bus-clock domain: runs on falling scl, but a frame only opens on the
   // system-clock start toggle, so deep sleep needs that clock running; scl
   // stands still between frames, hence the asynchronous reset to constants
   assign byte_in = {l_ff.shift[6:0], bus.sda};
   assign own_hit = (l_ff.addr_s2[7:1] == byte_in[7:1]) && !byte_in[0];
   assign gc_hit  = l_ff.addr_s2[`OWN_GCE] && (byte_in == `GC_ADDR);

   always_comb begin
      nxt_l = l_ff;
      // the toggle settles five system clocks before the start's own fall, so one
      // stage is enough and the frame can open on the very next fall
      nxt_l.start_s1 = s_ff.start_tgl;
      nxt_l.addr_s1 = s_ff.own_addr;
      nxt_l.addr_s2 = l_ff.addr_s1;
      nxt_l.ctl_s1 = {s_ff.ack_en, s_ff.en};
      nxt_l.ctl_s2 = l_ff.ctl_s1;
      if (l_ff.start_s1 != l_ff.frame_seen) begin
         // first falling edge after the start's own edge carries bit 7
         nxt_l.frame_seen = l_ff.start_s1;
         nxt_l.shift = {7'h00, bus.sda};
         nxt_l.cnt = 4'h1;
         nxt_l.first = 1'b1;
         nxt_l.addressed = 1'b0;
         nxt_l.gc = 1'b0;
         nxt_l.sda_oe = 1'b0;
      end else if (l_ff.cnt < `BIT_ACK) begin
         nxt_l.shift = byte_in;
         nxt_l.cnt = l_ff.cnt + 4'h1;
         if (l_ff.cnt == `BIT_LAST) begin
            if (l_ff.first) begin
               if (l_ff.ctl_s2[1] && l_ff.ctl_s2[0] && (own_hit || gc_hit)) begin
                  nxt_l.addressed = 1'b1;
                  nxt_l.gc = gc_hit && !own_hit;
                  nxt_l.sda_oe = 1'b1;
               end
            end else if (l_ff.addressed) begin
               nxt_l.sda_oe = l_ff.ctl_s2[1] && l_ff.ctl_s2[0];
            end
         end
      end else begin
         nxt_l.sda_oe = 1'b0;
         nxt_l.cnt = 4'h0;
         nxt_l.first = 1'b0;
         if (l_ff.addressed) begin
            nxt_l.ev_tgl = !l_ff.ev_tgl;
            nxt_l.ev_gc = l_ff.gc;
            nxt_l.ev_data = l_ff.shift;
            if (l_ff.first) begin
               nxt_l.ev_kind = two_wire_pkg::EV_ADDR;
            end else if (l_ff.sda_oe) begin
               nxt_l.ev_kind = two_wire_pkg::EV_DATA_ACK;
            end else begin
               nxt_l.ev_kind = two_wire_pkg::EV_DATA_NACK;
               nxt_l.addressed = 1'b0;
            end
         end
      end
   end

   always_ff @(negedge bus.scl or negedge rst_n) begin
      if (!rst_n) begin
         l_ff <= '0;
      end else begin
         l_ff <= nxt_l;
      end
   end

   // system-clock domain: registers, status and clock stretching
   assign start_det  = s_ff.scl_sync[1] && s_ff.scl_sync[2] && s_ff.sda_sync[2]
                       && !s_ff.sda_sync[1];
   assign stop_det   = s_ff.scl_sync[1] && s_ff.scl_sync[2] && !s_ff.sda_sync[2]
                       && s_ff.sda_sync[1];
   assign byte_event = s_ff.ev_s2 != s_ff.ev_seen;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.scl_sync = {s_ff.scl_sync[1:0], bus.scl};
      nxt_s.sda_sync = {s_ff.sda_sync[1:0], bus.sda};
      nxt_s.ev_s1 = l_ff.ev_tgl;
      nxt_s.ev_s2 = s_ff.ev_s1;
      nxt_s.ev_seen = s_ff.ev_s2;
      if (!sleep_deep) begin
         nxt_s.wake = 1'b0;
      end
      if (reg_wr) begin
         unique case (reg_addr)
            `REG_OWN_ADDR: nxt_s.own_addr = reg_wdata;
            `REG_CONTROL: begin
               if (reg_wdata[`CTL_FLAG]) begin
                  nxt_s.flag = 1'b0;
                  nxt_s.stretch = 1'b0;
               end
               nxt_s.ack_en = reg_wdata[`CTL_ACK];
               nxt_s.start_req = reg_wdata[`CTL_START];
               nxt_s.stop_req = reg_wdata[`CTL_STOP];
               nxt_s.en = reg_wdata[`CTL_EN];
               nxt_s.ie = reg_wdata[`CTL_IE];
            end
            `REG_STATUS: nxt_s.presc = reg_wdata[1:0];
            `REG_DATA: begin
               nxt_s.data = reg_wdata;
               nxt_s.wcol = !s_ff.flag;
            end
         endcase
      end
      if (!nxt_s.en) begin
         nxt_s.stretch = 1'b0;
      end
      if (start_det) begin
         nxt_s.start_tgl = !s_ff.start_tgl;
      end
      if ((start_det || stop_det) && s_ff.active) begin
         nxt_s.flag = 1'b1;
         nxt_s.status = `ST_STOP_RS;
         nxt_s.active = 1'b0;
      end
      // hardware set comes last so it wins over a clear in the same cycle
      if (byte_event && s_ff.en) begin
         nxt_s.flag = 1'b1;
         nxt_s.stretch = 1'b1;
         nxt_s.status = status_of(l_ff.ev_kind, l_ff.ev_gc, arb_lost);
         nxt_s.active = l_ff.ev_kind != two_wire_pkg::EV_DATA_NACK;
         if (sleep_deep) begin
            nxt_s.wake = 1'b1;
         end else begin
            nxt_s.data = l_ff.ev_data;
         end
      end
      unique case (reg_addr)
         `REG_OWN_ADDR: nxt_s.rdata = s_ff.own_addr;
         `REG_CONTROL:  nxt_s.rdata = {s_ff.flag, s_ff.ack_en, s_ff.start_req, s_ff.stop_req,
                                       s_ff.wcol, s_ff.en, 1'b0, s_ff.ie};
         `REG_STATUS:   nxt_s.rdata = {s_ff.status[7:3], 1'b0, s_ff.presc};
         `REG_DATA:     nxt_s.rdata = s_ff.data;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_ff <= '0;
         s_ff.scl_sync <= 3'h7;
         s_ff.sda_sync <= 3'h7;
         s_ff.own_addr <= `RST_OWN_ADDR;
         s_ff.status <= `RST_STATUS;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign reg_rdata         = s_ff.rdata;
   assign wake_request      = s_ff.wake;
   assign start_request     = s_ff.start_req;
   assign stop_request      = s_ff.stop_req;
   assign bit_rate_prescale = s_ff.presc;
   assign bus.scl_dev_out   = 1'b0;
   assign bus.scl_dev_oe    = s_ff.stretch;
   assign bus.sda_dev_out   = 1'b0;
   assign bus.sda_dev_oe    = l_ff.sda_oe;
endmodule

//--- two_wire_master_tx.sv
// bus master transmitter end: makes scl by dividing its clock, honours stretching
`timescale 1ns/100ps
`include "two_wire_defines.svh"
module two_wire_master_tx (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic [1:0] cmd_kind,
   input  wire logic [7:0] cmd_data,
   output logic            done,
   output logic            ack_seen,
   two_wire_if.host        bus
);
   localparam logic [7:0] HALF_LAST = 8'(`SCL_HALF_CYCLES - 1);
   localparam logic [7:0] HALF_MID  = 8'(`SCL_HALF_CYCLES / 2);

   two_wire_pkg::host_state_type h_ff;
   two_wire_pkg::host_state_type nxt_h;
   logic last;
   logic scl_high;

   assign last      = h_ff.cnt == HALF_LAST;
   assign scl_high  = h_ff.scl_sync[1];
   assign cmd_ready = h_ff.fsm == two_wire_pkg::H_IDLE;

   always_comb begin
      nxt_h = h_ff;
      nxt_h.scl_sync = {h_ff.scl_sync[0], bus.scl};
      nxt_h.sda_sync = {h_ff.sda_sync[0], bus.sda};
      nxt_h.done = 1'b0;
      nxt_h.cnt = h_ff.cnt + 8'h01;
      unique case (h_ff.fsm)
         two_wire_pkg::H_IDLE: begin
            nxt_h.cnt = 8'h00;
            if (cmd_valid) begin
               unique case (two_wire_pkg::cmd_kind_type'(cmd_kind))
                  two_wire_pkg::CMD_START: begin
                     nxt_h.fsm = h_ff.owned ? two_wire_pkg::H_RS_LO : two_wire_pkg::H_ST;
                     nxt_h.sda_oe = !h_ff.owned;
                  end
                  two_wire_pkg::CMD_WRITE: begin
                     nxt_h.fsm = two_wire_pkg::H_LO;
                     nxt_h.data = cmd_data;
                     nxt_h.idx = 4'h0;
                  end
                  two_wire_pkg::CMD_STOP: nxt_h.fsm = two_wire_pkg::H_SP_LO;
                  default: nxt_h.fsm = two_wire_pkg::H_IDLE;
               endcase
            end
         end
         two_wire_pkg::H_RS_LO: begin
            nxt_h.sda_oe = 1'b0;
            if (last) begin
               nxt_h.scl_oe = 1'b0;
               nxt_h.cnt = 8'h00;
               nxt_h.fsm = two_wire_pkg::H_RS_HI;
            end
         end
         two_wire_pkg::H_RS_HI: begin
            // a stretched clock keeps the count at zero until scl is seen high
            if (!scl_high) begin
               nxt_h.cnt = 8'h00;
            end else if (last) begin
               nxt_h.sda_oe = 1'b1;
               nxt_h.cnt = 8'h00;
               nxt_h.fsm = two_wire_pkg::H_ST;
            end
         end
         two_wire_pkg::H_ST: begin
            if (last) begin
               nxt_h.scl_oe = 1'b1;
               nxt_h.owned = 1'b1;
               nxt_h.done = 1'b1;
               nxt_h.fsm = two_wire_pkg::H_IDLE;
            end
         end
         two_wire_pkg::H_LO: begin
            if (h_ff.cnt == HALF_MID) begin
               nxt_h.sda_oe = (h_ff.idx != `BIT_ACK) && !h_ff.data[7];
            end
            if (last) begin
               nxt_h.scl_oe = 1'b0;
               nxt_h.cnt = 8'h00;
               nxt_h.fsm = two_wire_pkg::H_HI;
            end
         end
         two_wire_pkg::H_HI: begin
            if (!scl_high) begin
               nxt_h.cnt = 8'h00;
            end else if (last) begin
               nxt_h.scl_oe = 1'b1;
               nxt_h.cnt = 8'h00;
               if (h_ff.idx == `BIT_ACK) begin
                  nxt_h.ack = !h_ff.sda_sync[1];
                  nxt_h.done = 1'b1;
                  nxt_h.fsm = two_wire_pkg::H_IDLE;
               end else begin
                  nxt_h.data = {h_ff.data[6:0], 1'b0};
                  nxt_h.idx = h_ff.idx + 4'h1;
                  nxt_h.fsm = two_wire_pkg::H_LO;
               end
            end
         end
         two_wire_pkg::H_SP_LO: begin
            if (h_ff.cnt == HALF_MID) begin
               nxt_h.sda_oe = 1'b1;
            end
            if (last) begin
               nxt_h.scl_oe = 1'b0;
               nxt_h.cnt = 8'h00;
               nxt_h.fsm = two_wire_pkg::H_SP_HI;
            end
         end
         two_wire_pkg::H_SP_HI: begin
            if (!scl_high) begin
               nxt_h.cnt = 8'h00;
            end else if (last) begin
               nxt_h.sda_oe = 1'b0;
               nxt_h.owned = 1'b0;
               nxt_h.done = 1'b1;
               nxt_h.fsm = two_wire_pkg::H_IDLE;
            end
         end
         default: nxt_h.fsm = two_wire_pkg::H_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         h_ff <= '0;
         h_ff.fsm <= two_wire_pkg::H_IDLE;
         h_ff.scl_sync <= 2'h3;
         h_ff.sda_sync <= 2'h3;
      end else begin
         h_ff <= nxt_h;
      end
   end

   assign done             = h_ff.done;
   assign ack_seen         = h_ff.ack;
   assign bus.scl_host_out = 1'b0;
   assign bus.scl_host_oe  = h_ff.scl_oe;
   assign bus.sda_host_out = 1'b0;
   assign bus.sda_host_oe  = h_ff.sda_oe;
endmodule

//--- two_wire_slave_receiver_checker.sv
// concurrent checks on the two-wire link between bus master and slave receiver
`timescale 1ns/100ps
module two_wire_slave_receiver_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic scl_host_out,
   input wire logic scl_host_oe,
   input wire logic sda_host_out,
   input wire logic sda_host_oe,
   input wire logic scl_dev_out,
   input wire logic scl_dev_oe,
   input wire logic sda_dev_out,
   input wire logic sda_dev_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // cycles since scl was last seen falling, saturating so it never wraps
   logic [3:0] fall_cnt_ff;
   always_ff @(posedge clock) begin
      if (!rst_n)
         fall_cnt_ff <= 4'hF;
      else if ($fell(scl))
         fall_cnt_ff <= 4'h0;
      else if (fall_cnt_ff != 4'hF)
         fall_cnt_ff <= fall_cnt_ff + 4'h1;
   end

   sequence start_seq;
      $fell(sda) && scl && $past(scl);
   endsequence
   sequence stop_seq;
      $rose(sda) && scl && $past(scl);
   endsequence

   open_drain_a: assert property (!scl_host_out && !sda_host_out && !scl_dev_out && !sda_dev_out)
      else $error("a line is driven high instead of released");
   ack_edge_a: assert property (($rose(sda_dev_oe) || $fell(sda_dev_oe)) |-> !scl)
      else $error("acknowledge changed while scl high");
   ack_hold_a: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*8])
      else $error("acknowledge released too early");
   stretch_delay_a: assert property ($rose(scl_dev_oe) |-> fall_cnt_ff inside {[4'h1:4'h6]})
      else $error("clock stretch not right after a falling scl");
   low_phase_a: assert property ($rose(scl_host_oe) |-> scl_host_oe [*8])
      else $error("scl low phase shorter than half period");
   high_phase_a: assert property ($fell(scl_host_oe) |-> !scl_host_oe [*8])
      else $error("scl high phase shorter than half period");
   start_cond_a: assert property (start_seq |-> ##[4:16] scl_host_oe)
      else $error("start not followed by scl low");
   stop_idle_a: assert property (stop_seq |-> !scl_host_oe && !sda_host_oe && !scl_dev_oe)
      else $error("bus not released at stop");
endmodule

//--- tb_two_wire_slave_receiver.sv
// self-checking bench: bus master and slave receiver joined by the two-wire link
`timescale 1ns/100ps
`include "two_wire_defines.svh"
module tb_two_wire_slave_receiver;
   logic       clock = 1'h0;
   logic       rst_n = 1'h0;
   logic [1:0] reg_addr = 2'h0;
   logic       reg_wr = 1'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic       arb_lost = 1'h0;
   logic       sleep_deep = 1'h0;
   logic       wake_request;
   logic       start_request;
   logic       stop_request;
   logic [1:0] bit_rate_prescale;
   logic       cmd_valid = 1'h0;
   logic       cmd_ready;
   logic [1:0] cmd_kind = 2'h0;
   logic [7:0] cmd_data = 8'h00;
   logic       done;
   logic       ack_seen;
   logic [7:0] rv;
   int         n_mismatch = 0;
   int         total_checks = 0;
   localparam logic [1:0] S = two_wire_pkg::CMD_START;
   localparam logic [1:0] W = two_wire_pkg::CMD_WRITE;
   localparam logic [1:0] P = two_wire_pkg::CMD_STOP;

   always #5 clock = ~clock;

   two_wire_if link ();
   two_wire_slave_receiver two_wire_slave_receiver_i (.clock(clock), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .arb_lost(arb_lost), .sleep_deep(sleep_deep), .wake_request(wake_request),
      .start_request(start_request), .stop_request(stop_request),
      .bit_rate_prescale(bit_rate_prescale), .bus(link));
   two_wire_master_tx two_wire_master_tx_i (.clock(clock), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
      .cmd_data(cmd_data), .done(done), .ack_seen(ack_seen), .bus(link));
   two_wire_slave_receiver_checker two_wire_slave_receiver_checker_i (.clock(clock),
      .rst_n(rst_n), .scl_host_out(link.scl_host_out), .scl_host_oe(link.scl_host_oe),
      .sda_host_out(link.sda_host_out), .sda_host_oe(link.sda_host_oe),
      .scl_dev_out(link.scl_dev_out), .scl_dev_oe(link.scl_dev_oe),
      .sda_dev_out(link.sda_dev_out), .sda_dev_oe(link.sda_dev_oe),
      .scl(link.scl), .sda(link.sda));

   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk1(input string name, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clock);
      reg_wr <= 1'h0;
   endtask
   task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      @(posedge clock);
      #1;
      d = reg_rdata;
   endtask
   task automatic cmd(input logic [1:0] k, input logic [7:0] d);
      int i;
      @(posedge clock);
      cmd_valid <= 1'h1;
      cmd_kind <= k;
      cmd_data <= d;
      @(posedge clock);
      cmd_valid <= 1'h0;
      for (i = 0; i < 3000; i++) begin
         @(posedge clock);
         #1;
         if (done === 1'h1) break;
      end
      chk1("done", 1'h1, done);
   endtask
   // software side: wait for the flag, judge status and data, then release the bus
   task automatic service(input logic [7:0] st, input logic [7:0] d, input logic [7:0] ctl);
      logic [7:0] r;
      int i;
      r = 8'h00;
      for (i = 0; i < 400 && r[`CTL_FLAG] !== 1'h1; i++) reg_read(`REG_CONTROL, r);
      chk1("flag", 1'h1, r[`CTL_FLAG]);
      reg_read(`REG_STATUS, r);
      chk8("status", st, r & 8'hF8);
      // data codes have bit 7 set and bit 5 clear; the register is stale after a wake
      if (st[7] && !st[5] && !sleep_deep) begin
         reg_read(`REG_DATA, r);
         chk8("data", d, r);
      end
      reg_write(`REG_CONTROL, ctl);
   endtask
   task automatic xfer(input logic [1:0] k, input logic [7:0] d, input logic ack,
                       input logic [7:0] st, input logic [7:0] ctl);
      logic [7:0] r;
      fork
         cmd(k, d);
         if (st !== 8'h00) service(st, d, ctl);
      join
      if (k == W) chk1("ack_seen", ack, ack_seen);
      if (st === 8'h00) begin
         reg_read(`REG_CONTROL, r);
         chk1("flag", 1'h0, r[`CTL_FLAG]);
      end
   endtask

   task automatic test_regs;
      reg_read(`REG_OWN_ADDR, rv);
      chk8("own address", `RST_OWN_ADDR, rv);
      reg_read(`REG_CONTROL, rv);
      chk8("control", 8'h00, rv);
      reg_read(`REG_STATUS, rv);
      chk8("status", `RST_STATUS, rv);
      reg_write(`REG_STATUS, 8'h03);
      reg_read(`REG_STATUS, rv);
      chk8("status", 8'hFB, rv);
      chk8("prescale", 8'h03, {6'h00, bit_rate_prescale});
      reg_write(`REG_STATUS, 8'h00);
      reg_write(`REG_CONTROL, 8'h64);
      reg_read(`REG_CONTROL, rv);
      chk1("start_request", 1'h1, start_request);
      chk1("stop_request", 1'h0, stop_request);
      reg_write(`REG_CONTROL, 8'h54);
      reg_read(`REG_CONTROL, rv);
      chk1("stop_request", 1'h1, stop_request);
      chk1("start_request", 1'h0, start_request);
      reg_write(`REG_OWN_ADDR, 8'h55);
      reg_write(`REG_CONTROL, 8'h44);
      $display("register test done");
   endtask
   task automatic test_own_write;
      xfer(S, 8'h00, 1'h0, 8'h00, 8'h00);
      xfer(W, 8'h54, 1'h1, `ST_OWN_W, 8'hC4);
      xfer(W, 8'h3C, 1'h1, `ST_DATA_ACK, 8'h84);
      xfer(W, 8'hC3, 1'h0, `ST_DATA_NACK, 8'hC4);
      xfer(W, 8'h11, 1'h0, 8'h00, 8'h00);
      xfer(P, 8'h00, 1'h0, 8'h00, 8'h00);
      $display("own address write test done");
   endtask
   task automatic test_refuse;
      xfer(S, 8'h00, 1'h0, 8'h00, 8'h00);
      xfer(W, 8'h55, 1'h0, 8'h00, 8'h00);
      xfer(S, 8'h00, 1'h0, 8'h00, 8'h00);
      xfer(W, 8'h56, 1'h0, 8'h00, 8'h00);
      xfer(P, 8'h00, 1'h0, 8'h00, 8'h00);
      $display("refusal test done");
   endtask
   task automatic test_general;
      xfer(S, 8'h00, 1'h0, 8'h00, 8'h00);
      xfer(W, `GC_ADDR, 1'h1, `ST_GC, 8'hC4);
      xfer(W, 8'h5A, 1'h1, `ST_GC_DATA_ACK, 8'h84);
      xfer(W, 8'hA6, 1'h0, `ST_GC_DATA_NACK, 8'hC4);
      xfer(P, 8'h00, 1'h0, 8'h00, 8'h00);
      reg_write(`REG_OWN_ADDR, 8'h54);
      xfer(S, 8'h00, 1'h0, 8'h00, 8'h00);
      xfer(W, `GC_ADDR, 1'h0, 8'h00, 8'h00);
      xfer(P, 8'h00, 1'h0, 8'h00, 8'h00);
      reg_write(`REG_OWN_ADDR, 8'h55);
      $display("general call test done");
   endtask
   task automatic test_ack_off;
      reg_write(`REG_CONTROL, 8'h04);
      xfer(S, 8'h00, 1'h0, 8'h00, 8'h00);
      xfer(W, 8'h54, 1'h0, 8'h00, 8'h00);
      reg_write(`REG_CONTROL, 8'h44);
      xfer(S, 8'h00, 1'h0, 8'h00, 8'h00);
      xfer(W, 8'h54, 1'h1, `ST_OWN_W, 8'hC4);
      xfer(P, 8'h00, 1'h0, `ST_STOP_RS, 8'hC4);
      $display("ack disable test done");
   endtask
   task automatic test_arb;
      @(posedge clock);
      arb_lost <= 1'h1;
      xfer(S, 8'h00, 1'h0, 8'h00, 8'h00);
      xfer(W, 8'h54, 1'h1, `ST_ARB_OWN_W, 8'hC4);
      xfer(P, 8'h00, 1'h0, `ST_STOP_RS, 8'hC4);
      xfer(S, 8'h00, 1'h0, 8'h00, 8'h00);
      xfer(W, `GC_ADDR, 1'h1, `ST_ARB_GC, 8'hC4);
      xfer(P, 8'h00, 1'h0, `ST_STOP_RS, 8'hC4);
      @(posedge clock);
      arb_lost <= 1'h0;
      $display("lost arbitration test done");
   endtask
   task automatic test_sleep;
      @(posedge clock);
      sleep_deep <= 1'h1;
      xfer(S, 8'h00, 1'h0, 8'h00, 8'h00);
      xfer(W, 8'h54, 1'h1, `ST_OWN_W, 8'hC4);
      chk1("wake_request", 1'h1, wake_request);
      xfer(P, 8'h00, 1'h0, `ST_STOP_RS, 8'hC4);
      @(posedge clock);
      sleep_deep <= 1'h0;
      repeat (3) @(posedge clock);
      #1;
      chk1("wake_request", 1'h0, wake_request);
      $display("sleep test done");
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1'h1;
      repeat (4) @(posedge clock);
      test_regs();
      test_own_write();
      test_refuse();
      test_general();
      test_ack_off();
      test_arb();
      test_sleep();
      conclude();
   end

   // about 15 bus bytes of some 160 cycles each plus 18 starts and stops; the margin covers slow polling
   initial begin
      repeat (60000) @(posedge clock);
      n_mismatch++;
      conclude();
   end
endmodule
